// ==== ilfc_io_lines.sv ====
/*
 * io line function assignment, input conditioning, encoder counting and
 * program flow line tests, with an apb register slave.
 * assumes adc_data is produced on pclk; line, ssi and encoder pins are async.
 */
`timescale 1ns/100ps
// Operation
// - analog input may only be assigned to lines 4 to 7.
// - each analog channel yields a 10-bit unsigned sample.
// - analog values are averaged over the latest 5 ms of samples.
// - filtered analog result refreshes once every 120 us servo cycle.
// - a line holding a high speed function cannot be reassigned.
// - fast encoder filter accepts a level stable for 150 ns.
// - slow filter minimum level is 800 ns, or 300 ns in variant b.
// - variant a handles 1 MHz, step/direction slow up to 625 kHz.
// - variant b fast counts 10 MHz quadrature, 2.5 MHz step/direction.
// - variant b slow counts 5 MHz quadrature, 1.25 MHz step/direction.
// - encoder formats step/direction, quadrature and up/down are selectable.
// - lines 4 to 6 can carry internal or external encoder signals.
// - differential ssi receive is converted and driven onto lines 4 to 6.
// - internal encoder can drive ssi outputs differentially instead.
// - wait on line level stalls until the level matches, then resumes.
// - branch on line level jumps to target if matched, else continues.
// - after reset all seven lines are digital inputs.
// - input change seen after debounce time in servo cycles.
// - encoder counts sampled each servo cycle; scaling remainder carried forward.
module ilfc_io_lines #(
	parameter int TICK_CYC = ilfc_pkg::SERVO_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [6:0] line_in,
	output logic [6:0] line_out,
	output logic [6:0] line_oe,
	input wire logic [3:0][9:0] adc_data,
	input wire ilfc_pkg::ilfc_enc_type int_enc,
	input wire ilfc_pkg::ilfc_enc_type ssi_rx_p,
	input wire ilfc_pkg::ilfc_enc_type ssi_rx_n,
	output ilfc_pkg::ilfc_enc_type ssi_tx_p,
	output ilfc_pkg::ilfc_enc_type ssi_tx_n,
	output logic ssi_tx_oe,
	output ilfc_pkg::ilfc_flow_type flow
);
	typedef struct packed {
		logic [11:0] div;
		logic tick;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [31:0] ctrl;
		logic [7:0] deb_time;
		logic [6:0] out_lvl;
		ilfc_pkg::ilfc_func_type [6:0] func;
		logic [6:0] lin_s1;
		logic [6:0] lin_s2;
		logic [5:0] rx_s1;
		logic [5:0] rx_s2;
		logic [2:0] ie_s1;
		logic [2:0] ie_s2;
		logic [6:0][7:0] deb_cnt;
		logic [6:0] filt_in;
		logic conflict;
		logic flow_busy;
		logic flow_lvl;
		logic [2:0] flow_line;
		logic [7:0] flow_tgt;
		ilfc_pkg::ilfc_flow_type flow;
		logic [2:0] hs_prev;
		logic [15:0] delta_acc;
		logic [15:0] delta_smp;
		logic [7:0] frac;
		logic [31:0] pos;
		logic [6:0] line_out;
		logic [6:0] line_oe;
		ilfc_pkg::ilfc_enc_type tx_p;
		ilfc_pkg::ilfc_enc_type tx_n;
		logic tx_oe;
	} ilfc_st_type;
	ilfc_st_type s_r, s_nxt;

	logic [2:0] hs_raw;
	logic [2:0] hs_f;
	logic [2:0] rx_se;
	logic [2:0] buf_sig;
	logic [3:0][9:0] ana_avg;
	logic setup, done_acc, wr, hit, enc_on, cfg_bad, match;
	logic signed [1:0] step;
	logic signed [15:0] acc_in;
	logic signed [16:0] scale_s;
	logic signed [33:0] tot;
	logic signed [25:0] whole;
	logic [2:0] cfg_line;
	ilfc_pkg::ilfc_func_type cfg_fn;
	ilfc_pkg::ilfc_fmt_type fmt;

	function automatic logic pick(input logic [6:0] v, input logic [2:0] i);
		return (i < 3'h7) ? v[i] : 1'b0;
	endfunction : pick

	function automatic logic is_hs(input ilfc_pkg::ilfc_func_type f);
		return f == ilfc_pkg::FN_HSIN || f == ilfc_pkg::FN_HSOUT;
	endfunction : is_hs

	function automatic logic signed [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
		unique case ({p, c})
			4'h1, 4'h7, 4'he, 4'h8: return 2'sd1;
			4'h2, 4'hb, 4'hd, 4'h4: return -2'sd1;
			default: return 2'sd0;
		endcase
	endfunction : quad_step

	assign hs_raw = s_r.ctrl[ilfc_pkg::CTRL_RXDIFF_BIT] ? s_r.rx_s2[2:0] & ~s_r.rx_s2[5:3] :
		s_r.lin_s2[5:3];

	for (genvar g = 0; g < 3; g++) begin : g_hs
		ilfc_hsfilt u_filt (
			.pclk(pclk),
			.presetn(presetn),
			.din(hs_raw[g]),
			.slow(s_r.ctrl[ilfc_pkg::CTRL_SLOW_BIT]),
			.variant_b(s_r.ctrl[ilfc_pkg::CTRL_VAR_BIT]),
			.dout(hs_f[g])
		);
	end

	for (genvar g = 0; g < ilfc_pkg::NANA; g++) begin : g_ana
		ilfc_avg #(.N(ilfc_pkg::AVG_N), .W(ilfc_pkg::ADC_W)) u_avg (
			.pclk(pclk),
			.presetn(presetn),
			.tick(s_r.tick),
			.sample(adc_data[g]),
			.avg(ana_avg[g])
		);
	end

	always_comb begin
		s_nxt = s_r;
		// pin synchronisers
		s_nxt.lin_s1 = line_in;
		s_nxt.lin_s2 = s_r.lin_s1;
		s_nxt.rx_s1 = {ssi_rx_n, ssi_rx_p};
		s_nxt.rx_s2 = s_r.rx_s1;
		s_nxt.ie_s1 = int_enc;
		s_nxt.ie_s2 = s_r.ie_s1;
		// servo cycle divider
		s_nxt.tick = (s_r.div == 12'(TICK_CYC - 1));
		s_nxt.div = s_nxt.tick ? 12'h000 : s_r.div + 12'h001;
		// input debounce per line
		for (int i = 0; i < ilfc_pkg::NLINES; i++) begin
			if (s_r.tick) begin
				if (s_r.lin_s2[i] == s_r.filt_in[i]) begin
					s_nxt.deb_cnt[i] = 8'h00;
				end else if (s_r.deb_cnt[i] >= s_r.deb_time) begin
					s_nxt.filt_in[i] = s_r.lin_s2[i];
					s_nxt.deb_cnt[i] = 8'h00;
				end else begin
					s_nxt.deb_cnt[i] = s_r.deb_cnt[i] + 8'h01;
				end
			end
		end
		// encoder counting
		fmt = ilfc_pkg::ilfc_fmt_type'(s_r.ctrl[ilfc_pkg::CTRL_FMT_LSB +: 2]);
		s_nxt.hs_prev = hs_f;
		unique case (fmt)
			ilfc_pkg::FMT_STEPDIR: step = (hs_f[0] & ~s_r.hs_prev[0]) ?
				(hs_f[1] ? -2'sd1 : 2'sd1) : 2'sd0;
			ilfc_pkg::FMT_QUAD: step = quad_step(s_r.hs_prev[1:0], hs_f[1:0]);
			ilfc_pkg::FMT_UPDN: step = (hs_f[0] & ~s_r.hs_prev[0]) ? 2'sd1 :
				((hs_f[1] & ~s_r.hs_prev[1]) ? -2'sd1 : 2'sd0);
			default: step = 2'sd0;
		endcase
		enc_on = s_r.func[3] == ilfc_pkg::FN_HSIN && s_r.func[4] == ilfc_pkg::FN_HSIN;
		acc_in = $signed(s_r.delta_acc) + (enc_on ? 16'(step) : 16'sd0);
		scale_s = $signed({1'b0, s_r.ctrl[ilfc_pkg::CTRL_SCALE_LSB +: 16]});
		tot = 34'(acc_in) * 34'(scale_s) + 34'($signed({1'b0, s_r.frac}));
		whole = tot[33:8];
		s_nxt.delta_acc = acc_in;
		if (s_r.tick) begin
			s_nxt.delta_smp = acc_in;
			s_nxt.delta_acc = 16'h0000;
			s_nxt.pos = s_r.pos + 32'(whole);
			s_nxt.frac = tot[7:0];
		end
		// line drivers
		rx_se = s_r.rx_s2[2:0] & ~s_r.rx_s2[5:3];
		buf_sig = s_r.ctrl[ilfc_pkg::CTRL_RXDIFF_BIT] ? rx_se :
			(s_r.ctrl[ilfc_pkg::CTRL_BUFSRC_BIT] ? hs_f : s_r.ie_s2);
		for (int i = 0; i < ilfc_pkg::NLINES; i++) begin
			s_nxt.line_oe[i] = 1'b0;
			s_nxt.line_out[i] = 1'b0;
			if (s_r.func[i] == ilfc_pkg::FN_DOUT) begin
				s_nxt.line_oe[i] = 1'b1;
				s_nxt.line_out[i] = s_r.out_lvl[i];
			end else if (s_r.func[i] == ilfc_pkg::FN_HSOUT && i >= 3 && i <= 5) begin
				s_nxt.line_oe[i] = 1'b1;
				s_nxt.line_out[i] = buf_sig[i-3];
			end
		end
		s_nxt.tx_oe = s_r.ctrl[ilfc_pkg::CTRL_TXDIFF_BIT];
		s_nxt.tx_p = s_nxt.tx_oe ? s_r.ie_s2 : 3'h0;
		s_nxt.tx_n = s_nxt.tx_oe ? ~s_r.ie_s2 : 3'h0;
		// program flow line tests
		s_nxt.flow.done = 1'b0;
		match = pick(s_r.filt_in, s_r.flow_line) == s_r.flow_lvl;
		if (s_r.flow_busy && match) begin
			s_nxt.flow_busy = 1'b0;
			s_nxt.flow.done = 1'b1;
			s_nxt.flow.jump = 1'b0;
		end
		// apb slave
		setup = psel & ~penable;
		done_acc = psel & penable & s_r.pready;
		wr = done_acc & pwrite & ~s_r.pslverr;
		hit = (paddr[1:0] == 2'h0) && (paddr <= ilfc_pkg::OFS_ANA3);
		s_nxt.pready = setup;
		s_nxt.pslverr = setup & ~hit;
		if (setup) begin
			unique case (paddr)
				ilfc_pkg::OFS_CTRL: s_nxt.prdata = s_r.ctrl;
				ilfc_pkg::OFS_CFG: s_nxt.prdata = {11'h000, s_r.func};
				ilfc_pkg::OFS_DEBOUNCE: s_nxt.prdata = {24'h000000, s_r.deb_time};
				ilfc_pkg::OFS_OUT: s_nxt.prdata = {25'h0000000, s_r.out_lvl};
				ilfc_pkg::OFS_STATUS: s_nxt.prdata = {21'h000000, s_r.flow.jump,
					s_r.flow_busy, s_r.conflict, 1'b0, s_r.filt_in};
				ilfc_pkg::OFS_FLOW: s_nxt.prdata = {16'h0000, s_r.flow_tgt, 4'h0,
					s_r.flow_lvl, s_r.flow_line};
				ilfc_pkg::OFS_ENC: s_nxt.prdata = 32'($signed(s_r.delta_smp));
				ilfc_pkg::OFS_POS: s_nxt.prdata = s_r.pos;
				default: begin
					s_nxt.prdata = 32'h0000_0000;
					for (int k = 0; k < ilfc_pkg::NANA; k++)
						if (paddr == ilfc_pkg::OFS_ANA0 + 12'(4 * k) &&
							s_r.func[k+3] == ilfc_pkg::FN_AIN)
							s_nxt.prdata = {22'h000000, ana_avg[k]};
				end
			endcase
		end
		cfg_line = pwdata[2:0];
		cfg_fn = ilfc_pkg::ilfc_func_type'(pwdata[ilfc_pkg::CFG_FN_LSB +: 3]);
		cfg_bad = cfg_line == 3'h7 || pwdata[ilfc_pkg::CFG_FN_LSB +: 3] > 3'h4 ||
			(cfg_fn == ilfc_pkg::FN_AIN && cfg_line < 3'h3) ||
			(is_hs(cfg_fn) && (cfg_line < 3'h3 || cfg_line > 3'h5)) ||
			(cfg_line != 3'h7 && is_hs(s_r.func[cfg_line]) &&
			s_r.func[cfg_line] != cfg_fn);
		if (wr) begin
			unique case (paddr)
				ilfc_pkg::OFS_CTRL: s_nxt.ctrl = pwdata;
				ilfc_pkg::OFS_DEBOUNCE: s_nxt.deb_time = pwdata[7:0];
				ilfc_pkg::OFS_OUT: s_nxt.out_lvl = pwdata[6:0];
				ilfc_pkg::OFS_STATUS: if (pwdata[ilfc_pkg::STATUS_CONFLICT_BIT])
					s_nxt.conflict = 1'b0;
				ilfc_pkg::OFS_CFG: if (!cfg_bad)
					s_nxt.func[cfg_line] = cfg_fn;
				ilfc_pkg::OFS_FLOW: if (!s_r.flow_busy) begin
					s_nxt.flow_line = pwdata[2:0];
					s_nxt.flow_lvl = pwdata[ilfc_pkg::FLOW_LEVEL_BIT];
					s_nxt.flow_tgt = pwdata[ilfc_pkg::FLOW_TGT_LSB +: 8];
					s_nxt.flow.target = pwdata[ilfc_pkg::FLOW_TGT_LSB +: 8];
					if (pwdata[ilfc_pkg::FLOW_OP_BIT]) begin
						s_nxt.flow.done = 1'b1;
						s_nxt.flow.jump = pick(s_r.filt_in, pwdata[2:0]) ==
							pwdata[ilfc_pkg::FLOW_LEVEL_BIT];
					end else begin
						s_nxt.flow_busy = 1'b1;
					end
				end
				default: s_nxt.ctrl = s_r.ctrl;
			endcase
		end
		// set wins over a same cycle clear
		if (wr && paddr == ilfc_pkg::OFS_CFG && cfg_bad)
			s_nxt.conflict = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ctrl <= ilfc_pkg::CTRL_RST;
			s_r.deb_time <= ilfc_pkg::DEBOUNCE_RST;
			s_r.func <= {7{ilfc_pkg::FN_DIN}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign line_out = s_r.line_out;
	assign line_oe = s_r.line_oe;
	assign ssi_tx_p = s_r.tx_p;
	assign ssi_tx_n = s_r.tx_n;
	assign ssi_tx_oe = s_r.tx_oe;
	assign flow = s_r.flow;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	analog_lines_a: assert property (s_r.func[0] != ilfc_pkg::FN_AIN &&
		s_r.func[1] != ilfc_pkg::FN_AIN && s_r.func[2] != ilfc_pkg::FN_AIN)
		else $error("analog function on line 1 to 3");
	hs_lock_a: assert property ((wr && paddr == ilfc_pkg::OFS_CFG &&
		cfg_line < 3'h7 && is_hs(s_r.func[cfg_line]) && s_r.func[cfg_line] != cfg_fn)
		|=> $stable(s_r.func) && s_r.conflict)
		else $error("high speed line was reassigned");
	input_default_a: assert property ((s_r.func == {7{ilfc_pkg::FN_DIN}})
		|=> s_r.line_oe == 7'h00)
		else $error("line driven while all lines are inputs");
	debounce_tick_a: assert property ($changed(s_r.filt_in) |-> $past(s_r.tick))
		else $error("input accepted outside a servo cycle");
	tick_period_a: assert property (s_r.tick |=> !s_r.tick [*2])
		else $error("servo tick too frequent");
	conflict_set_a: assert property ((wr && paddr == ilfc_pkg::OFS_CFG && cfg_bad)
		|=> s_r.conflict && $stable(s_r.func))
		else $error("conflict not flagged");
	wait_resume_a: assert property ((s_r.flow_busy && match)
		|=> s_r.flow.done && !s_r.flow_busy && !s_r.flow.jump)
		else $error("wait did not resume on matching level");
	wait_hold_a: assert property ((s_r.flow_busy && !match) |=> !s_r.flow.done)
		else $error("wait resumed before level matched");
	branch_eval_a: assert property ((wr && paddr == ilfc_pkg::OFS_FLOW &&
		!s_r.flow_busy && pwdata[ilfc_pkg::FLOW_OP_BIT]) |=> s_r.flow.done &&
		s_r.flow.jump == ($past(pick(s_r.filt_in, pwdata[2:0])) ==
		$past(pwdata[ilfc_pkg::FLOW_LEVEL_BIT])))
		else $error("branch decision wrong");
	sample_frac_a: assert property (!s_r.tick |=> $stable(s_r.frac) && $stable(s_r.pos))
		else $error("encoder scaling moved outside a servo cycle");

	conflict_c: cover property (wr && paddr == ilfc_pkg::OFS_CFG && cfg_bad);
	wait_done_c: cover property (s_r.flow_busy ##[1:50] s_r.flow.done);
	branch_jump_c: cover property (s_r.flow.done && s_r.flow.jump);
	ana_read_c: cover property (done_acc && !pwrite && paddr == ilfc_pkg::OFS_ANA0);
endmodule : ilfc_io_lines

// ==== ilfc_pkg.sv ====
/*
 * shared constants, field layouts and types of the io line function block.
 * assumes a 25 MHz pclk and a 120 us servo cycle derived from it.
 */
package ilfc_pkg;
	localparam int CLK_MHZ = 25;
	localparam int SERVO_US = 120;
	localparam int SERVO_CYC = SERVO_US * CLK_MHZ;
	localparam int AVG_MS = 5;
	localparam int AVG_N = (AVG_MS * 1000 + SERVO_US - 1) / SERVO_US;
	localparam int FAST_NS = 150;
	localparam int SLOW_A_NS = 800;
	localparam int SLOW_B_NS = 300;
	localparam int NLINES = 7;
	localparam int ADC_W = 10;
	localparam int NANA = 4;

	function automatic int ns_to_cyc(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction : ns_to_cyc

	localparam int FAST_CYC = ns_to_cyc(FAST_NS);
	localparam int SLOW_A_CYC = ns_to_cyc(SLOW_A_NS);
	localparam int SLOW_B_CYC = ns_to_cyc(SLOW_B_NS);

	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CFG = 12'h004;
	localparam logic [11:0] OFS_DEBOUNCE = 12'h008;
	localparam logic [11:0] OFS_OUT = 12'h00c;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_FLOW = 12'h014;
	localparam logic [11:0] OFS_ENC = 12'h018;
	localparam logic [11:0] OFS_POS = 12'h01c;
	localparam logic [11:0] OFS_ANA0 = 12'h020;
	localparam logic [11:0] OFS_ANA3 = 12'h02c;

	localparam int CTRL_SLOW_BIT = 0;
	localparam int CTRL_VAR_BIT = 1;
	localparam int CTRL_FMT_LSB = 2;
	localparam int CTRL_BUFSRC_BIT = 4;
	localparam int CTRL_RXDIFF_BIT = 5;
	localparam int CTRL_TXDIFF_BIT = 6;
	localparam int CTRL_SCALE_LSB = 16;
	localparam int STATUS_CONFLICT_BIT = 8;
	localparam int CFG_FN_LSB = 4;
	localparam int FLOW_LEVEL_BIT = 3;
	localparam int FLOW_OP_BIT = 4;
	localparam int FLOW_TGT_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0100_0000;
	localparam logic [7:0] DEBOUNCE_RST = 8'h00;

	typedef enum logic [2:0] {
		FN_DIN = 3'h0,
		FN_DOUT = 3'h1,
		FN_AIN = 3'h2,
		FN_HSIN = 3'h3,
		FN_HSOUT = 3'h4
	} ilfc_func_type;

	typedef enum logic [1:0] {
		FMT_STEPDIR = 2'h0,
		FMT_QUAD = 2'h1,
		FMT_UPDN = 2'h2
	} ilfc_fmt_type;

	typedef struct packed {
		logic z;
		logic b;
		logic a;
	} ilfc_enc_type;

	typedef struct packed {
		logic done;
		logic jump;
		logic [7:0] target;
	} ilfc_flow_type;
endpackage : ilfc_pkg

// ==== ilfc_hsfilt.sv ====
/*
 * minimum level filter for one high speed input.
 * assumes din is already synchronised to pclk.
 */
`timescale 1ns/100ps
module ilfc_hsfilt (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	input wire logic slow,
	input wire logic variant_b,
	output logic dout
);
	typedef struct packed {
		logic [4:0] cnt;
		logic lvl;
		logic [4:0] age;
		logic [1:0] sel;
	} ilfc_hf_type;
	ilfc_hf_type s_r, s_nxt;
	logic [4:0] lim;

	always_comb begin
		if (!slow)
			lim = 5'(ilfc_pkg::FAST_CYC);
		else if (variant_b)
			lim = 5'(ilfc_pkg::SLOW_B_CYC);
		else
			lim = 5'(ilfc_pkg::SLOW_A_CYC);
		s_nxt = s_r;
		s_nxt.sel = {variant_b, slow};
		s_nxt.age = (s_r.sel != {variant_b, slow}) ? 5'h00 :
			((s_r.age == 5'h1f) ? s_r.age : s_r.age + 5'h01);
		if (din == s_r.lvl) begin
			s_nxt.cnt = 5'h00;
		end else if (s_r.cnt >= lim - 5'h01) begin
			s_nxt.lvl = din;
			s_nxt.cnt = 5'h00;
		end else begin
			s_nxt.cnt = s_r.cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign dout = s_r.lvl;

	fast_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		($changed(s_r.lvl) && !slow && s_r.age > 5'h05) |->
		($past(din, 1) == s_r.lvl && $past(din, 4) == s_r.lvl && $past(din, 5) != s_r.lvl))
		else $error("fast filter accepted a level held other than 150 ns");
	slow_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		($changed(s_r.lvl) && slow && variant_b && s_r.age > 5'h09) |->
		($past(din, 1) == s_r.lvl && $past(din, 8) == s_r.lvl && $past(din, 9) != s_r.lvl))
		else $error("slow filter accepted a level held other than 300 ns");
endmodule : ilfc_hsfilt

// ==== ilfc_avg.sv ====
/*
 * sliding average of one analog channel over the last n servo samples.
 * assumes tick is a one cycle pulse per servo cycle and sample is on pclk.
 */
`timescale 1ns/100ps
module ilfc_avg #(
	parameter int N = ilfc_pkg::AVG_N,
	parameter int W = ilfc_pkg::ADC_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic [W-1:0] sample,
	output logic [W-1:0] avg
);
	localparam int IW = $clog2(N);
	localparam int SW = W + IW + 1;
	localparam int RECIP = (65536 + N / 2) / N;
	typedef struct packed {
		logic [N-1:0][W-1:0] ring;
		logic [IW-1:0] idx;
		logic [SW-1:0] sum;
		logic [W-1:0] avg;
	} ilfc_av_type;
	ilfc_av_type s_r, s_nxt;
	logic [SW+16:0] prod;

	function automatic logic [SW-1:0] ring_total(input logic [N-1:0][W-1:0] r);
		logic [SW-1:0] t;
		t = '0;
		for (int i = 0; i < N; i++)
			t = t + SW'(r[i]);
		return t;
	endfunction : ring_total

	always_comb begin
		s_nxt = s_r;
		prod = '0;
		if (tick) begin
			s_nxt.sum = s_r.sum + SW'(sample) - SW'(s_r.ring[s_r.idx]);
			s_nxt.ring[s_r.idx] = sample;
			s_nxt.idx = (s_r.idx == IW'(N - 1)) ? '0 : s_r.idx + IW'(1);
			prod = (SW + 17)'(s_nxt.sum) * (SW + 17)'(RECIP);
			s_nxt.avg = prod[W+15:16];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign avg = s_r.avg;

	avg_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(tick) |-> $stable(s_r.avg))
		else $error("analog average moved outside a servo tick");
	window_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.sum == ring_total(s_r.ring))
		else $error("average sum does not match the sample window");
endmodule : ilfc_avg

// ==== ilfc_ext_model.sv ====
/* far side model: switches, sensors and encoder on the io lines.
 assumes ext_en/ext_lvl change just after pclk edges. */
`timescale 1ns/100ps
module ilfc_ext_model (
	input wire logic pclk,
	input wire logic [6:0] ext_en,
	input wire logic [6:0] ext_lvl,
	input wire logic [6:0] line_out,
	input wire logic [6:0] line_oe,
	input wire ilfc_pkg::ilfc_enc_type enc,
	output logic [6:0] line_in,
	output ilfc_pkg::ilfc_enc_type ssi_rx_p,
	output ilfc_pkg::ilfc_enc_type ssi_rx_n
);
	logic flip = 1'b0;
	always @(posedge pclk) flip <= ~flip;
	// lines 1..3 pulled up, 4..7 float and show a toggling level
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (line_oe[i]) line_in[i] = line_out[i];
			else if (ext_en[i]) line_in[i] = ext_lvl[i];
			else line_in[i] = (i < 3) ? 1'b1 : flip;
		end
	end
	assign ssi_rx_p = enc;
	assign ssi_rx_n = ~enc;
endmodule : ilfc_ext_model

// ==== tb_io_line_function_conditioning.sv ====
/* self-checking bench of the io line block with an apb master.
 assumes TICK_CYC shortened to 50 cycles. */
`timescale 1ns/100ps
module tb_io_line_function_conditioning;
	localparam int TK = 50;
	localparam logic [7:0] QSEQ = 8'h1e;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, tx_oe, jmp;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [6:0] line_in, line_out, line_oe, ext_en, ext_lvl;
	logic [3:0][9:0] adc;
	logic [9:0] v;
	logic [7:0] tgt;
	ilfc_pkg::ilfc_enc_type int_enc, rxp, rxn, txp, txn;
	ilfc_pkg::ilfc_flow_type flow;
	int err_count, n_compared, cyc, dn, n;
	int cfg_m[7];
	ilfc_io_lines #(.TICK_CYC(TK)) ilfc_io_lines_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .adc_data(adc), .int_enc(int_enc),
		.ssi_rx_p(rxp), .ssi_rx_n(rxn), .ssi_tx_p(txp), .ssi_tx_n(txn), .ssi_tx_oe(tx_oe),
		.flow(flow));
	ilfc_ext_model ilfc_ext_model_inst (.pclk(pclk), .ext_en(ext_en), .ext_lvl(ext_lvl),
		.line_out(line_out), .line_oe(line_oe), .enc(int_enc), .line_in(line_in),
		.ssi_rx_p(rxp), .ssi_rx_n(rxn));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end
	always @(posedge pclk) if (flow.done === 1'b1) begin
		dn <= dn + 1;
		jmp <= flow.jump;
		tgt <= flow.target;
	end
	task results();
		if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	function automatic logic [31:0] cfg_exp();
		logic [31:0] c;
		c = 32'h0;
		for (int i = 0; i < 7; i++) c[3*i +: 3] = 3'(cfg_m[i]);
		return c;
	endfunction : cfg_exp
	// model of the assignment table: hs lines locked, analog only on 4..7
	task set_fn(input int i, input int fn);
		if (cfg_m[i] < 3 && !(fn == 2 && i < 3) && !(fn >= 3 && (i < 3 || i > 5))) cfg_m[i] = fn;
		apb(1'b1, ilfc_pkg::OFS_CFG, 32'((fn << 4) | i));
	endtask : set_fn
	task wait_dn();
		int k;
		k = 0;
		while (dn == n && k < 300) begin
			@(posedge pclk);
			k++;
		end
	endtask : wait_dn
	task pulses(input int cnt, input int w);
		repeat (cnt) begin
			ext_lvl[3] <= 1'b1;
			repeat (w) @(posedge pclk);
			ext_lvl[3] <= 1'b0;
			repeat (w) @(posedge pclk);
		end
	endtask : pulses
	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
		ext_en = 0; ext_lvl = 0; int_enc = 0; cyc = 0; dn = 0; jmp = 0; tgt = 0;
		err_count = 0; n_compared = 0; n = 0;
		foreach (cfg_m[i]) cfg_m[i] = 0;
		v = 10'($urandom(32'ha3bb8ce9));
		for (int i = 0; i < 4; i++) adc[i] = 10'($urandom);
		adc[3] = v;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST);
		rd(ilfc_pkg::OFS_CFG, 32'h0);
		chk(line_oe, 7'h00);
		apb(1'b0, 12'h030, 32'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
		set_fn(0, 2);
		rd(ilfc_pkg::OFS_CFG, cfg_exp());
		set_fn(6, 2);
		rd(ilfc_pkg::OFS_CFG, cfg_exp());
		set_fn(1, 1);
		apb(1'b1, ilfc_pkg::OFS_OUT, 32'h2);
		repeat (2) @(posedge pclk);
		chk({line_oe[1], line_out[1]}, 2'b11);
		set_fn(3, 3);
		set_fn(3, 1);
		rd(ilfc_pkg::OFS_CFG, cfg_exp());
		apb(1'b0, ilfc_pkg::OFS_STATUS, 32'h0);
		chk(r[8], 1'b1);
		apb(1'b1, ilfc_pkg::OFS_STATUS, 32'h100);
		apb(1'b0, ilfc_pkg::OFS_STATUS, 32'h0);
		chk(r[8], 1'b0);
		set_fn(5, 4);
		int_enc <= 3'b100;
		repeat (6) @(posedge pclk);
		chk({line_oe[5], line_out[5]}, 2'b11);
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST | 32'h40);
		int_enc <= 3'b101;
		repeat (6) @(posedge pclk);
		chk({tx_oe, txp, txn}, 7'b1101010);
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST | 32'h60);
		int_enc <= 3'b001;
		repeat (6) @(posedge pclk);
		chk({line_oe[5], line_out[5]}, 2'b10);
		apb(1'b1, ilfc_pkg::OFS_DEBOUNCE, 32'h1);
		ext_en[2] <= 1'b1;
		apb(1'b0, ilfc_pkg::OFS_STATUS, 32'h0);
		chk(r[2], 1'b1);
		repeat (3 * TK + 10) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_STATUS, 32'h0);
		chk(r[2], 1'b0);
		ext_en[0] <= 1'b1;
		repeat (3 * TK + 10) @(posedge pclk);
		n = dn;
		apb(1'b1, ilfc_pkg::OFS_FLOW, 32'h8);
		repeat (200) @(posedge pclk);
		chk(dn, n);
		apb(1'b0, ilfc_pkg::OFS_STATUS, 32'h0);
		chk(r[9], 1'b1);
		ext_lvl[0] <= 1'b1;
		wait_dn();
		chk(dn, n + 1);
		chk(jmp, 1'b0);
		n = dn;
		apb(1'b1, ilfc_pkg::OFS_FLOW, 32'h5a18);
		wait_dn();
		chk({jmp, tgt}, 9'h15a);
		n = dn;
		apb(1'b1, ilfc_pkg::OFS_FLOW, 32'h10);
		wait_dn();
		chk(jmp, 1'b0);
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST);
		set_fn(4, 3);
		ext_en[4:3] <= 2'b11;
		ext_lvl[4:3] <= 2'b10;
		repeat (4 * TK) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_POS, 32'h0);
		n = int'(r);
		pulses(10, 8);
		pulses(10, 2);
		repeat (3 * TK) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_POS, 32'h0);
		chk(32'(int'(r) - n) == 32'd10 || 32'(n - int'(r)) == 32'd10, 1'b1);
		n = int'(r);
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST | 32'h1);
		pulses(10, 8);
		repeat (3 * TK) @(posedge pclk);
		rd(ilfc_pkg::OFS_POS, 32'(n));
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST | 32'h4);
		for (int i = 0; i < 4; i++) begin
			ext_lvl[4:3] <= QSEQ[7 - 2 * i -: 2];
			repeat (8) @(posedge pclk);
		end
		repeat (3 * TK) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_POS, 32'h0);
		chk(32'(int'(r) - n) == 32'd4 || 32'(n - int'(r)) == 32'd4, 1'b1);
		n = int'(r);
		apb(1'b1, ilfc_pkg::OFS_CTRL, ilfc_pkg::CTRL_RST | 32'h3);
		pulses(10, 10);
		repeat (3 * TK) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_POS, 32'h0);
		chk(32'(int'(r) - n) == 32'd10 || 32'(n - int'(r)) == 32'd10, 1'b1);
		repeat (44 * TK) @(posedge pclk);
		apb(1'b0, ilfc_pkg::OFS_ANA3, 32'h0);
		chk(r == 32'(v) || r == 32'(v) - 32'h1, 1'b1);
		results();
	end
endmodule : tb_io_line_function_conditioning
